// [hw/usb_irq_pkg.sv]
package usb_irq_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_POWER     = 6'h01;
    localparam logic [5:0] IDX_IN_FLAGS  = 6'h02;
    localparam logic [5:0] IDX_OUT_FLAGS = 6'h04;
    localparam logic [5:0] IDX_BUS_FLAGS = 6'h06;
    localparam logic [5:0] IDX_IN_EN     = 6'h07;
    localparam logic [5:0] IDX_OUT_EN    = 6'h09;
    localparam logic [5:0] IDX_BUS_EN    = 6'h0b;

    localparam logic [7:0] IN_EN_RESET  = 8'h0f;
    localparam logic [7:0] OUT_EN_RESET = 8'h0e;
    localparam logic [7:0] BUS_EN_RESET = 8'h06;
    localparam logic [7:0] POWER_RESET  = 8'h00;
    localparam logic [7:0] FLAGS_RESET  = 8'h00;

    localparam logic [7:0] IN_EN_MASK  = 8'h0f;
    localparam logic [7:0] OUT_EN_MASK = 8'h0e;
    localparam logic [7:0] BUS_EN_MASK = 8'h0f;
    localparam logic [7:0] POWER_MASK  = 8'h01;

    localparam int BUS_SUSPEND_BIT    = 0;
    localparam int BUS_RESUME_BIT     = 1;
    localparam int BUS_RESET_BIT      = 2;
    localparam int BUS_SOF_BIT        = 3;
    localparam int SUSPEND_DETECT_BIT = 0;
    localparam int CONTROL_EP_BIT     = 0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] PID_ACK     = 4'h2;

    typedef enum logic [1:0] {
        TX_IDLE    = 2'b00,
        TX_WAIT_HS = 2'b01,
        TX_DONE    = 2'b11
    } tx_state_e;
endpackage

// [hw/usb_function_irq_enable_and_sie.sv]
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module usb_function_irq_enable_and_sie (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [7:0] s_axi_awaddr,
    input  wire logic       s_axi_awvalid,
    output logic            s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0] s_axi_wstrb,
    input  wire logic       s_axi_wvalid,
    output logic            s_axi_wready,
    output logic [1:0]      s_axi_bresp,
    output logic            s_axi_bvalid,
    input  wire logic       s_axi_bready,
    input  wire logic [7:0] s_axi_araddr,
    input  wire logic       s_axi_arvalid,
    output logic            s_axi_arready,
    output logic [31:0]     s_axi_rdata,
    output logic [1:0]      s_axi_rresp,
    output logic            s_axi_rvalid,
    input  wire logic       s_axi_rready,
    input  wire logic       rx_packet_done,
    input  wire logic       rx_packet_ok,
    input  wire logic [1:0] rx_endpoint,
    input  wire logic       tx_packet_sent,
    input  wire logic [1:0] tx_endpoint,
    input  wire logic       host_handshake_ack,
    input  wire logic       tx_abort,
    input  wire logic       frame_expected,
    input  wire logic       bus_reset_detected,
    input  wire logic       resume_detected,
    input  wire logic       suspend_detected,
    output logic            handshake_valid,
    output logic [3:0]      handshake_pid,
    output logic            suspended,
    output logic            irq
);

    logic        aw_held_reg, aw_held_next;
    logic [5:0]  aw_idx_reg, aw_idx_next;
    logic        w_held_reg, w_held_next;
    logic [7:0]  w_data_reg, w_data_next;
    logic        w_lane_reg, w_lane_next;
    logic        awready_reg, awready_next;
    logic        wready_reg, wready_next;
    logic        bvalid_reg, bvalid_next;
    logic [1:0]  bresp_reg, bresp_next;
    logic        arready_reg, arready_next;
    logic        rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0]  rresp_reg, rresp_next;

    logic [7:0]  in_endpoint_irq_enable_reg, in_endpoint_irq_enable_next;
    logic [7:0]  out_endpoint_irq_enable_reg, out_endpoint_irq_enable_next;
    logic [7:0]  bus_event_irq_enable_reg, bus_event_irq_enable_next;
    logic [7:0]  power_ctl_reg, power_ctl_next;
    logic [7:0]  in_endpoint_irq_flags_reg, in_endpoint_irq_flags_next;
    logic [7:0]  out_endpoint_irq_flags_reg, out_endpoint_irq_flags_next;
    logic [7:0]  bus_event_irq_flags_reg, bus_event_irq_flags_next;
    logic        suspended_reg, suspended_next;
    logic        irq_reg, irq_next;
    logic        hs_valid_reg, hs_valid_next;
    logic [3:0]  hs_pid_reg, hs_pid_next;
    usb_irq_pkg::tx_state_e tx_state_reg, tx_state_next;
    logic [1:0]  tx_ep_reg, tx_ep_next;

    logic        wr_fire;
    logic        rd_fire;
    logic [5:0]  rd_idx;
    logic        wr_known;
    logic [7:0]  in_set, out_set, bus_set;
    logic [7:0]  in_clr, out_clr, bus_clr;

    // bus slave: address and data taken independently, response after both
    always_comb begin
        aw_held_next = aw_held_reg;
        aw_idx_next  = aw_idx_reg;
        w_held_next  = w_held_reg;
        w_data_next  = w_data_reg;
        w_lane_next  = w_lane_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        wr_fire      = 1'b0;
        rd_fire      = s_axi_arvalid && arready_reg;
        rd_idx       = s_axi_araddr[7:2];
        if (s_axi_awvalid && awready_reg) begin
            aw_held_next = 1'b1;
            aw_idx_next  = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && wready_reg) begin
            w_held_next = 1'b1;
            w_data_next = s_axi_wdata[7:0];
            w_lane_next = s_axi_wstrb[0];
        end
        if (aw_held_reg && w_held_reg && !bvalid_reg) begin
            wr_fire      = 1'b1;
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = wr_known ? usb_irq_pkg::RESP_OKAY : usb_irq_pkg::RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (rd_fire) begin
            rvalid_next = 1'b1;
            rresp_next  = usb_irq_pkg::RESP_OKAY;
            rdata_next  = 32'h0;
            unique case (rd_idx)
                usb_irq_pkg::IDX_POWER:     rdata_next[7:0] = power_ctl_reg;
                usb_irq_pkg::IDX_IN_FLAGS:  rdata_next[7:0] = in_endpoint_irq_flags_reg;
                usb_irq_pkg::IDX_OUT_FLAGS: rdata_next[7:0] = out_endpoint_irq_flags_reg;
                usb_irq_pkg::IDX_BUS_FLAGS: rdata_next[7:0] = bus_event_irq_flags_reg;
                usb_irq_pkg::IDX_IN_EN:     rdata_next[7:0] = in_endpoint_irq_enable_reg;
                usb_irq_pkg::IDX_OUT_EN:    rdata_next[7:0] = out_endpoint_irq_enable_reg;
                usb_irq_pkg::IDX_BUS_EN:    rdata_next[7:0] = bus_event_irq_enable_reg;
                default:                    rresp_next = usb_irq_pkg::RESP_SLVERR;
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        awready_next = !aw_held_next;
        wready_next  = !w_held_next;
        arready_next = !rvalid_next;
    end

    // the three enable registers and the power control bit
    always_comb begin
        in_endpoint_irq_enable_next  = in_endpoint_irq_enable_reg;
        out_endpoint_irq_enable_next = out_endpoint_irq_enable_reg;
        bus_event_irq_enable_next    = bus_event_irq_enable_reg;
        power_ctl_next               = power_ctl_reg;
        wr_known                     = 1'b1;
        unique case (aw_idx_reg)
            usb_irq_pkg::IDX_IN_EN:
                if (wr_fire && w_lane_reg) begin
                    in_endpoint_irq_enable_next = w_data_reg
                        & usb_irq_pkg::IN_EN_MASK;
                end
            usb_irq_pkg::IDX_OUT_EN:
                if (wr_fire && w_lane_reg) begin
                    out_endpoint_irq_enable_next = w_data_reg
                        & usb_irq_pkg::OUT_EN_MASK;
                end
            usb_irq_pkg::IDX_BUS_EN:
                if (wr_fire && w_lane_reg) begin
                    bus_event_irq_enable_next = w_data_reg
                        & usb_irq_pkg::BUS_EN_MASK;
                end
            usb_irq_pkg::IDX_POWER:
                if (wr_fire && w_lane_reg) begin
                    power_ctl_next = w_data_reg & usb_irq_pkg::POWER_MASK;
                end
            usb_irq_pkg::IDX_IN_FLAGS,
            usb_irq_pkg::IDX_OUT_FLAGS,
            usb_irq_pkg::IDX_BUS_FLAGS:
                wr_known = 1'b1;
            default:
                wr_known = 1'b0;
        endcase
    end

    // serial engine events, pending flags and interrupt
    always_comb begin
        tx_state_next  = tx_state_reg;
        tx_ep_next     = tx_ep_reg;
        suspended_next = suspended_reg;
        hs_valid_next  = 1'b0;
        hs_pid_next    = hs_pid_reg;
        in_set         = 8'h00;
        out_set        = 8'h00;
        bus_set        = 8'h00;
        // whole good packets only; bad ones get neither flag nor handshake
        if (rx_packet_done && rx_packet_ok) begin
            if (rx_endpoint == 2'h0) begin
                in_set[usb_irq_pkg::CONTROL_EP_BIT] = 1'b1;
            end else begin
                out_set[rx_endpoint] = 1'b1;
            end
            hs_valid_next = 1'b1;
            hs_pid_next   = usb_irq_pkg::PID_ACK;
        end
        unique case (tx_state_reg)
            usb_irq_pkg::TX_IDLE:
                if (tx_packet_sent) begin
                    tx_state_next = usb_irq_pkg::TX_WAIT_HS;
                    tx_ep_next    = tx_endpoint;
                end
            usb_irq_pkg::TX_WAIT_HS:
                if (host_handshake_ack) begin
                    tx_state_next = usb_irq_pkg::TX_DONE;
                end else if (tx_abort) begin
                    tx_state_next = usb_irq_pkg::TX_IDLE;
                end
            usb_irq_pkg::TX_DONE: begin
                in_set[tx_ep_reg] = 1'b1;
                tx_state_next     = usb_irq_pkg::TX_IDLE;
            end
            default:
                tx_state_next = usb_irq_pkg::TX_IDLE;
        endcase
        bus_set[usb_irq_pkg::BUS_SOF_BIT]     = frame_expected;
        bus_set[usb_irq_pkg::BUS_RESET_BIT]   = bus_reset_detected;
        bus_set[usb_irq_pkg::BUS_RESUME_BIT]  = resume_detected && suspended_reg;
        bus_set[usb_irq_pkg::BUS_SUSPEND_BIT] = suspend_detected
            && power_ctl_reg[usb_irq_pkg::SUSPEND_DETECT_BIT];
        if (bus_reset_detected || (resume_detected && suspended_reg)) begin
            suspended_next = 1'b0;
        end else if (bus_set[usb_irq_pkg::BUS_SUSPEND_BIT]) begin
            suspended_next = 1'b1;
        end
        in_clr  = (rd_fire && rd_idx == usb_irq_pkg::IDX_IN_FLAGS) ? 8'hff : 8'h00;
        out_clr = (rd_fire && rd_idx == usb_irq_pkg::IDX_OUT_FLAGS) ? 8'hff : 8'h00;
        bus_clr = (rd_fire && rd_idx == usb_irq_pkg::IDX_BUS_FLAGS) ? 8'hff : 8'h00;
        // a set in the clearing cycle survives
        in_endpoint_irq_flags_next  = ((in_endpoint_irq_flags_reg & ~in_clr) | in_set)
            & usb_irq_pkg::IN_EN_MASK;
        out_endpoint_irq_flags_next = ((out_endpoint_irq_flags_reg & ~out_clr) | out_set)
            & usb_irq_pkg::OUT_EN_MASK;
        bus_event_irq_flags_next    = ((bus_event_irq_flags_reg & ~bus_clr) | bus_set)
            & usb_irq_pkg::BUS_EN_MASK;
        irq_next = |(in_endpoint_irq_flags_reg & in_endpoint_irq_enable_reg)
                || |(out_endpoint_irq_flags_reg & out_endpoint_irq_enable_reg)
                || |(bus_event_irq_flags_reg & bus_event_irq_enable_reg);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_idx_reg  <= 6'h00;
            w_held_reg  <= 1'b0;
            w_data_reg  <= 8'h00;
            w_lane_reg  <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= usb_irq_pkg::RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0;
            rresp_reg   <= usb_irq_pkg::RESP_OKAY;
            in_endpoint_irq_enable_reg  <= usb_irq_pkg::IN_EN_RESET;
            out_endpoint_irq_enable_reg <= usb_irq_pkg::OUT_EN_RESET;
            bus_event_irq_enable_reg    <= usb_irq_pkg::BUS_EN_RESET;
            power_ctl_reg               <= usb_irq_pkg::POWER_RESET;
            in_endpoint_irq_flags_reg   <= usb_irq_pkg::FLAGS_RESET;
            out_endpoint_irq_flags_reg  <= usb_irq_pkg::FLAGS_RESET;
            bus_event_irq_flags_reg     <= usb_irq_pkg::FLAGS_RESET;
            suspended_reg <= 1'b0;
            irq_reg       <= 1'b0;
            hs_valid_reg  <= 1'b0;
            hs_pid_reg    <= 4'h0;
            tx_state_reg  <= usb_irq_pkg::TX_IDLE;
            tx_ep_reg     <= 2'h0;
        end else begin
            aw_held_reg <= aw_held_next;
            aw_idx_reg  <= aw_idx_next;
            w_held_reg  <= w_held_next;
            w_data_reg  <= w_data_next;
            w_lane_reg  <= w_lane_next;
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
            in_endpoint_irq_enable_reg  <= in_endpoint_irq_enable_next;
            out_endpoint_irq_enable_reg <= out_endpoint_irq_enable_next;
            bus_event_irq_enable_reg    <= bus_event_irq_enable_next;
            power_ctl_reg               <= power_ctl_next;
            in_endpoint_irq_flags_reg   <= in_endpoint_irq_flags_next;
            out_endpoint_irq_flags_reg  <= out_endpoint_irq_flags_next;
            bus_event_irq_flags_reg     <= bus_event_irq_flags_next;
            suspended_reg <= suspended_next;
            irq_reg       <= irq_next;
            hs_valid_reg  <= hs_valid_next;
            hs_pid_reg    <= hs_pid_next;
            tx_state_reg  <= tx_state_next;
            tx_ep_reg     <= tx_ep_next;
        end
    end

    assign s_axi_awready   = awready_reg;
    assign s_axi_wready    = wready_reg;
    assign s_axi_bvalid    = bvalid_reg;
    assign s_axi_bresp     = bresp_reg;
    assign s_axi_arready   = arready_reg;
    assign s_axi_rvalid    = rvalid_reg;
    assign s_axi_rdata     = rdata_reg;
    assign s_axi_rresp     = rresp_reg;
    assign handshake_valid = hs_valid_reg;
    assign handshake_pid   = hs_pid_reg;
    assign suspended       = suspended_reg;
    assign irq             = irq_reg;

endmodule
`default_nettype wire

// [verif/usb_irq_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module usb_irq_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        rx_packet_done,
    input wire logic        rx_packet_ok,
    input wire logic        host_handshake_ack,
    input wire logic        frame_expected,
    input wire logic        bus_reset_detected,
    input wire logic        resume_detected,
    input wire logic        suspend_detected,
    input wire logic        handshake_valid,
    input wire logic [3:0]  handshake_pid,
    input wire logic        suspended,
    input wire logic        irq
);
    logic ev_any;
    // any engine event able to set a flag
    assign ev_any = (rx_packet_done && rx_packet_ok) || host_handshake_ack || frame_expected
        || bus_reset_detected || resume_detected || suspend_detected;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_rx_handshake: assert property (rx_packet_done && rx_packet_ok |=> handshake_valid)
        else $error("good packet without handshake");
    a_hs_cause: assert property (handshake_valid
        |-> $past(rx_packet_done && rx_packet_ok))
        else $error("handshake without good packet");
    a_hs_pid: assert property (handshake_valid |-> handshake_pid == usb_irq_pkg::PID_ACK)
        else $error("handshake code wrong");
    a_irq_cause: assert property ($rose(irq) |-> $past(ev_any, 2) || $past(ev_any, 3)
        || $past(ev_any, 4) || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("interrupt rose without cause");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    a_susp_set: assert property ($rose(suspended) |-> $past(suspend_detected)
        || $past(suspend_detected, 2))
        else $error("suspended without suspend event");
    a_susp_clear: assert property (suspended && (resume_detected || bus_reset_detected)
        |-> ##[1:2] !suspended)
        else $error("suspended not left");
    c_rx_irq: cover property (rx_packet_done && rx_packet_ok ##2 irq);
    c_suspend: cover property ($rose(suspended));
    c_read_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule
`default_nettype wire

// [verif/usb_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module usb_host_model (
    input  wire logic  aclk,
    output logic       rx_packet_done,
    output logic       rx_packet_ok,
    output logic [1:0] rx_endpoint,
    output logic       tx_packet_sent,
    output logic [1:0] tx_endpoint,
    output logic       host_handshake_ack,
    output logic       tx_abort,
    output logic       frame_expected,
    output logic       bus_reset_detected,
    output logic       resume_detected,
    output logic       suspend_detected
);
    initial begin
        {rx_packet_done, rx_packet_ok, rx_endpoint, tx_packet_sent, tx_endpoint} = '0;
        {host_handshake_ack, tx_abort, frame_expected, bus_reset_detected} = '0;
        {resume_detected, suspend_detected} = '0;
    end
    // k: 0 rx, 1 tx acked, 2 tx lost, 3 frame, 4 reset, 5 resume, 6 suspend
    task automatic ev(input int k, input logic [1:0] ep, input logic ok, input int dly);
        @(posedge aclk);
        rx_packet_done <= (k == 0);
        rx_packet_ok <= ok;
        rx_endpoint <= ep;
        tx_packet_sent <= (k == 1 || k == 2);
        tx_endpoint <= ep;
        {frame_expected, bus_reset_detected, resume_detected, suspend_detected}
            <= (k > 2) ? 4'h8 >> (k - 3) : 4'h0;
        @(posedge aclk);
        {rx_packet_done, tx_packet_sent, frame_expected, bus_reset_detected} <= '0;
        {resume_detected, suspend_detected} <= '0;
        rx_packet_ok <= ~ok;
        rx_endpoint <= ~ep;
        if (k == 1 || k == 2) begin
            repeat (dly) @(posedge aclk);
            host_handshake_ack <= (k == 1);
            tx_abort <= (k == 2);
            @(posedge aclk);
            {host_handshake_ack, tx_abort} <= 2'b00;
            tx_endpoint <= ~ep;
        end
    endtask
endmodule
`default_nettype wire

// [verif/test_usb_function_irq_enable_and_sie.sv]
`timescale 1ns/10ps
`default_nettype none
module test_usb_function_irq_enable_and_sie;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h1, handshake_pid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rx_endpoint, tx_endpoint;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        rx_packet_done, rx_packet_ok, tx_packet_sent, host_handshake_ack, tx_abort;
    logic        frame_expected, bus_reset_detected, resume_detected, suspend_detected;
    logic        handshake_valid, suspended, irq;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    logic [31:0] seed = 32'hca65cafb;
    int          bad_count = 0;
    int          comparisons = 0;
    localparam logic [5:0] en_idx [3] = '{6'h07, 6'h09, 6'h0b};
    localparam logic [7:0] en_rst [3] = '{8'h0f, 8'h0e, 8'h06};
    localparam logic [7:0] en_msk [3] = '{8'h0f, 8'h0e, 8'h0f};
    localparam logic [5:0] in_f = usb_irq_pkg::IDX_IN_FLAGS;
    localparam logic [5:0] out_f = usb_irq_pkg::IDX_OUT_FLAGS;
    localparam logic [5:0] bus_f = usb_irq_pkg::IDX_BUS_FLAGS;
    localparam logic [1:0] ok = usb_irq_pkg::RESP_OKAY;

    usb_function_irq_enable_and_sie i_dut (.*);
    usb_host_model i_host (.*);

    always #4 aclk = ~aclk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [5:0] i, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        bq.push_back(r);
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] i, input logic [7:0] e, input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        rq.push_back({r, 24'h0, e});
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
    endtask

    task automatic settle(input logic e);
        repeat (5) @(posedge aclk);
        chk("irq", {33'h0, e}, {33'h0, irq});
    endtask

    // results are matched to the oldest note as they appear
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
            chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
            chk("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
    end

    task automatic test_done;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        test_done;
    end

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(bus_f, 8'h00, ok);
        for (int k = 0; k < 3; k++) begin
            rd(en_idx[k], en_rst[k], ok);
            wr(en_idx[k], 32'hffff_ffff, ok);
            rd(en_idx[k], en_msk[k], ok);
            seed = lfsr(seed);
            wr(en_idx[k], seed, ok);
            rd(en_idx[k], seed[7:0] & en_msk[k], ok);
        end
        wr(6'h3f, 32'h1, usb_irq_pkg::RESP_SLVERR);
        rd(6'h3f, 8'h00, usb_irq_pkg::RESP_SLVERR);
        wr(en_idx[0], 32'h0f, ok);
        wr(en_idx[1], 32'h00, ok);
        wr(en_idx[2], 32'h0f, ok);
        i_host.ev(0, 2'd2, 1'b1, 0);
        settle(1'b0);
        rd(out_f, 8'h04, ok);
        rd(out_f, 8'h00, ok);
        wr(en_idx[1], 32'h0e, ok);
        i_host.ev(0, 2'd3, 1'b1, 0);
        settle(1'b1);
        rd(out_f, 8'h08, ok);
        settle(1'b0);
        i_host.ev(0, 2'd1, 1'b0, 0);
        settle(1'b0);
        rd(out_f, 8'h00, ok);
        i_host.ev(0, 2'd0, 1'b1, 0);
        settle(1'b1);
        rd(in_f, 8'h01, ok);
        for (int k = 1; k < 4; k++) begin
            fork
                i_host.ev(1, k[1:0], 1'b1, 12);
                begin
                    repeat (4) @(posedge aclk);
                    rd(in_f, 8'h00, ok);
                end
            join
            settle(1'b1);
            rd(in_f, 8'h01 << k, ok);
        end
        i_host.ev(2, 2'd1, 1'b1, 3);
        settle(1'b0);
        for (int k = 3; k < 5; k++) begin
            i_host.ev(k, 2'd0, 1'b1, 0);
            settle(1'b1);
            rd(bus_f, 8'h08 >> (k - 3), ok);
        end
        i_host.ev(6, 2'd0, 1'b1, 0);
        settle(1'b0);
        rd(bus_f, 8'h00, ok);
        wr(usb_irq_pkg::IDX_POWER, 32'h1, ok);
        wr(en_idx[2], 32'h0e, ok);
        i_host.ev(6, 2'd0, 1'b1, 0);
        settle(1'b0);
        chk("suspended", 34'h1, {33'h0, suspended});
        wr(en_idx[2], 32'h0f, ok);
        settle(1'b1);
        rd(bus_f, 8'h01, ok);
        i_host.ev(5, 2'd0, 1'b1, 0);
        settle(1'b1);
        rd(bus_f, 8'h02, ok);
        chk("suspended", 34'h0, {33'h0, suspended});
        test_done;
    end
endmodule

bind usb_function_irq_enable_and_sie usb_irq_checker i_chk (.*);
`default_nettype wire
